// file: design/ckg_chan.sv
/*
 One clock output channel: source select, inversion, gating and the
 forced states for power-down, disable and unlocked synthesizer.
 Assumes clock levels arrive sampled on i_clk.
*/
module ckg_chan (
   input  logic     i_clk,
   input  logic     i_rst_n,
   input  logic     i_pd_n,
   input  logic     i_locked,
   input  logic     i_ref_lvl,
   input  logic     i_syn_lvl,
   ckg_chan_if.chan bus
);
   logic lvl_r;
   logic lvl_nxt;
   logic oe_r;
   logic oe_nxt;
   wire  src    = bus.byp ? i_ref_lvl : i_syn_lvl;
   wire  wave   = src ^ bus.inv;
   wire  active = bus.en & bus.gate;

   always_comb
   begin
      lvl_nxt = 1'b0;
      oe_nxt  = 1'b1;
      if (!i_pd_n)
         lvl_nxt = 1'b0;
      else if (!active)
         oe_nxt = ~bus.hiz;
      else if (!i_locked)
         lvl_nxt = bus.hold_hi;
      else
         lvl_nxt = wave;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         lvl_r <= 1'b0;
         oe_r  <= 1'b1;
      end
      else
      begin
         lvl_r <= lvl_nxt;
         oe_r  <= oe_nxt;
      end
   end

   assign bus.lvl = lvl_r;
   assign bus.oe  = oe_r;

   AST_BYPASS_COPY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_pd_n && active && i_locked && bus.byp
      |=> bus.lvl == ($past(i_ref_lvl) ^ $past(bus.inv)))
      else $error("bypass output is not the input clock copy");
   AST_DISABLED_STATE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_pd_n && !active |=> !bus.lvl && (bus.oe == !$past(bus.hiz)))
      else $error("disabled output in wrong state");
   AST_PD_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !i_pd_n |=> !bus.lvl && bus.oe)
      else $error("output not held low in power-down");
endmodule

// file: design/ckg_chan_if.sv
/*
 Per-output configuration and result bundle between the top and one
 output channel. Assumes the top drives the configuration side.
*/
interface ckg_chan_if;
   logic en;
   logic byp;
   logic inv;
   logic hiz;
   logic hold_hi;
   logic gate;
   logic lvl;
   logic oe;
   modport ctl  (output en, byp, inv, hiz, hold_hi, gate, input lvl, oe);
   modport chan (input en, byp, inv, hiz, hold_hi, gate, output lvl, oe);
endinterface

// file: design/ckg_pkg.sv
/*
 Constants and types of the clock output configuration block:
 register offsets, field positions, limits and reset values.
 Assumes one 125 MHz clock and a plain register port of 32-bit words.
*/
// Behaviour
// - Output drives only when its configuration enable and gate pin are high.
// - In differential mode the pair gate pin alone gates both legs.
// - With three single-ended outputs the first gate pin works normally.
// - First two outputs may form one differential output in four formats.
// - Any output may carry the input clock copy instead of the synthesized clock.
// - Each output, bypassed or not, may be inverted.
// - Spread applies to synthesized outputs, never to bypassed ones.
// - Deviation: center to 3% in 0.125% steps, down to 4% in 0.25%.
// - Modulation rate programmable from 30 kHz to 130 kHz.
// - Input is a crystal to 50 MHz or a reference clock to 200 MHz.
// - Internal load capacitance 4.36 pF to 20.36 pF in 0.05 pF steps.
// - Loading modes: internal only, external only, or both together.
// - Internal load capacitors bypassed when the reference clock is selected.
// - Each single-ended output has four selectable drive strengths.
// - Each output frequency programmable from 8 kHz to 200 MHz.
// - Master writes every configuration register; device applies the values.
// - Until lock, single-ended outputs low, differential pair low/high.
// - Disabled output state is high impedance or driven low.
// - Power-down pin low holds all outputs low; high resumes operation.
package ckg_pkg;
   localparam int         ADDR_W     = 8;
   localparam int         DATA_W     = 32;
   localparam int         NCH        = 3;
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_LOAD   = 8'h04;
   localparam logic [7:0] OFF_OUT    = 8'h08;
   localparam logic [7:0] OFF_SS     = 8'h0C;
   localparam logic [7:0] OFF_FREQ0  = 8'h10;
   localparam logic [7:0] OFF_FREQ1  = 8'h14;
   localparam logic [7:0] OFF_FREQ2  = 8'h18;
   localparam logic [7:0] OFF_STAT   = 8'h1C;
   localparam int         F_SRC      = 0;
   localparam int         F_LOAD     = 1;
   localparam int         F_DIFF     = 3;
   localparam int         F_FMT      = 4;
   localparam int         OC_STRIDE  = 8;
   localparam int         F_EN       = 0;
   localparam int         F_BYP      = 1;
   localparam int         F_INV      = 2;
   localparam int         F_HIZ      = 3;
   localparam int         F_DRV      = 4;
   localparam int         F_SS_EN    = 0;
   localparam int         F_SS_DOWN  = 1;
   localparam int         F_SS_DEV   = 8;
   localparam int         F_SS_RATE  = 16;
   localparam int         CAP_W      = 9;
   localparam int         DEV_W      = 5;
   localparam int         RATE_W     = 8;
   localparam int         FREQ_W     = 28;
   localparam logic [8:0] CAP_MIN    = 9'h000;
   localparam logic [8:0] CAP_MAX    = 9'h140;
   localparam logic [8:0] CAP_RST    = 9'h0B4;
   localparam logic [4:0] DEV_MIN    = 5'h01;
   localparam logic [4:0] DEV_CTR_MAX = 5'h18;
   localparam logic [4:0] DEV_DN_MAX = 5'h10;
   localparam logic [7:0] RATE_MIN   = 8'h1E;
   localparam logic [7:0] RATE_MAX   = 8'h82;
   localparam logic [27:0] FREQ_MIN  = 28'h0001F40;
   localparam logic [27:0] FREQ_MAX  = 28'hBEBC200;
   localparam logic [27:0] FREQ_RST  = 28'h17D7840;
   localparam logic       SRC_RST    = 1'b0;
   localparam logic       DIFF_RST   = 1'b0;
   localparam logic [7:0] OUT_RST    = 8'h00;
   localparam logic       SS_EN_RST  = 1'b0;
   typedef enum logic [1:0] {CKG_LOAD_INT, CKG_LOAD_EXT, CKG_LOAD_BOTH, CKG_LOAD_RSVD}
      ckg_load_t;
   typedef enum logic [1:0] {CKG_FMT_PECL, CKG_FMT_LVDS, CKG_FMT_HCSL, CKG_FMT_CML}
      ckg_fmt_t;
endpackage

// file: design/ckg_sat.sv
/*
 Saturating limiter: clips a written field into its legal range.
 Assumes LO is not above HI.
*/
module ckg_sat #(
   parameter int           W  = 8,
   parameter logic [W-1:0] LO = '0,
   parameter logic [W-1:0] HI = '1
) (
   input  logic [W-1:0] i_val,
   output logic [W-1:0] o_val
);
   wire below = (i_val < LO);
   wire above = (i_val > HI);
   assign o_val = below ? LO : (above ? HI : i_val);
endmodule

// file: design/ckg_top.sv
/*
 Clock output configuration control: configuration registers on a plain
 port, crystal load and spread settings, and three output channels.
 Assumes pins and clock levels are synchronous to i_clk, and that the
 synthesizer reports lock on i_pll_locked.
*/
// Implementation choices: the address-and-strobe port and the register offsets.
module ckg_top (
   input  logic        i_clk,
   input  logic        i_nrst,
   input  logic [7:0]  i_addr,
   input  logic [31:0] i_wdata,
   input  logic        i_wr,
   input  logic        i_rd,
   output logic [31:0] o_rdata,
   input  logic        i_ref_clk_lvl,
   input  logic        i_synth_clk_lvl,
   input  logic        i_pll_locked,
   input  logic        i_power_down_n_pin,
   input  logic        i_first_gate_pin,
   input  logic        i_pair_gate_pin,
   input  logic        i_third_gate_pin,
   output logic        o_first_clock_output,
   output logic        o_first_clock_oe,
   output logic        o_second_clock_output,
   output logic        o_second_clock_oe,
   output logic        o_third_clock_output,
   output logic        o_third_clock_oe,
   output logic        o_src_ref,
   output logic        o_cap_int_en,
   output logic        o_cap_ext_en,
   output logic [8:0]  o_cap_code,
   output logic        o_diff_mode,
   output logic [1:0]  o_diff_fmt,
   output logic [5:0]  o_drive,
   output logic        o_ss_en,
   output logic        o_ss_down,
   output logic [4:0]  o_ss_dev,
   output logic [7:0]  o_ss_rate,
   output logic [2:0]  o_ss_applied,
   output logic [27:0] o_freq0,
   output logic [27:0] o_freq1,
   output logic [27:0] o_freq2
);
   logic                rst_s1_r;
   logic                rst_n;
   logic                src_r;
   ckg_pkg::ckg_load_t  load_r;
   logic                diff_r;
   ckg_pkg::ckg_fmt_t   fmt_r;
   logic [8:0]          cap_r;
   logic [2:0]          en_r;
   logic [2:0]          byp_r;
   logic [2:0]          inv_r;
   logic [2:0]          hiz_r;
   logic [5:0]          drv_r;
   logic                ss_en_r;
   logic                ss_down_r;
   logic [4:0]          dev_r;
   logic [7:0]          rate_r;
   logic [27:0]         freq0_r;
   logic [27:0]         freq1_r;
   logic [27:0]         freq2_r;
   logic [31:0]         rdata_r;
   logic [31:0]         rdata_nxt;
   logic [8:0]          cap_sat;
   logic [4:0]          dev_ctr_sat;
   logic [4:0]          dev_dn_sat;
   logic [7:0]          rate_sat;
   logic [27:0]         freq_sat;
   logic [2:0]          eff_en;
   logic [2:0]          eff_byp;
   logic [2:0]          eff_inv;
   logic [2:0]          eff_hiz;
   logic [2:0]          eff_hold;
   logic [2:0]          eff_gate;
   logic [2:0]          ch_lvl;
   logic [2:0]          ch_oe;
   logic [31:0]         stat_word;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   // Write decode
   wire wr_ctrl  = i_wr && (i_addr == ckg_pkg::OFF_CTRL);
   wire wr_load  = i_wr && (i_addr == ckg_pkg::OFF_LOAD);
   wire wr_out   = i_wr && (i_addr == ckg_pkg::OFF_OUT);
   wire wr_ss    = i_wr && (i_addr == ckg_pkg::OFF_SS);
   wire wr_freq0 = i_wr && (i_addr == ckg_pkg::OFF_FREQ0);
   wire wr_freq1 = i_wr && (i_addr == ckg_pkg::OFF_FREQ1);
   wire wr_freq2 = i_wr && (i_addr == ckg_pkg::OFF_FREQ2);

   wire [1:0] load_wr = i_wdata[ckg_pkg::F_LOAD +: 2];
   // Reserved loading code leaves the mode unchanged
   wire load_ok = (load_wr != 2'(ckg_pkg::CKG_LOAD_RSVD));
   wire ss_down_wr = i_wdata[ckg_pkg::F_SS_DOWN];

   // load code clipped to the legal span
   ckg_sat #(
      .W  (ckg_pkg::CAP_W),
      .LO (ckg_pkg::CAP_MIN),
      .HI (ckg_pkg::CAP_MAX)
   ) u_sat_cap (
      .i_val (i_wdata[ckg_pkg::CAP_W-1:0]),
      .o_val (cap_sat)
   );

   // center spread steps of 0.125 %
   ckg_sat #(
      .W  (ckg_pkg::DEV_W),
      .LO (ckg_pkg::DEV_MIN),
      .HI (ckg_pkg::DEV_CTR_MAX)
   ) u_sat_dev_ctr (
      .i_val (i_wdata[ckg_pkg::F_SS_DEV +: ckg_pkg::DEV_W]),
      .o_val (dev_ctr_sat)
   );

   // down spread steps of 0.25 %
   ckg_sat #(
      .W  (ckg_pkg::DEV_W),
      .LO (ckg_pkg::DEV_MIN),
      .HI (ckg_pkg::DEV_DN_MAX)
   ) u_sat_dev_dn (
      .i_val (i_wdata[ckg_pkg::F_SS_DEV +: ckg_pkg::DEV_W]),
      .o_val (dev_dn_sat)
   );

   ckg_sat #(
      .W  (ckg_pkg::RATE_W),
      .LO (ckg_pkg::RATE_MIN),
      .HI (ckg_pkg::RATE_MAX)
   ) u_sat_rate (
      .i_val (i_wdata[ckg_pkg::F_SS_RATE +: ckg_pkg::RATE_W]),
      .o_val (rate_sat)
   );

   ckg_sat #(
      .W  (ckg_pkg::FREQ_W),
      .LO (ckg_pkg::FREQ_MIN),
      .HI (ckg_pkg::FREQ_MAX)
   ) u_sat_freq (
      .i_val (i_wdata[ckg_pkg::FREQ_W-1:0]),
      .o_val (freq_sat)
   );

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         src_r  <= ckg_pkg::SRC_RST;
         load_r <= ckg_pkg::CKG_LOAD_INT;
         diff_r <= ckg_pkg::DIFF_RST;
         fmt_r  <= ckg_pkg::CKG_FMT_PECL;
      end
      else if (wr_ctrl)
      begin
         src_r  <= i_wdata[ckg_pkg::F_SRC];
         load_r <= load_ok ? ckg_pkg::ckg_load_t'(load_wr) : load_r;
         diff_r <= i_wdata[ckg_pkg::F_DIFF];
         fmt_r  <= ckg_pkg::ckg_fmt_t'(i_wdata[ckg_pkg::F_FMT +: 2]);
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         cap_r <= ckg_pkg::CAP_RST;
      else if (wr_load)
         cap_r <= cap_sat;
   end

   genvar g;
   generate
      for (g = 0; g < ckg_pkg::NCH; g++)
      begin : g_out
         localparam int B = g * ckg_pkg::OC_STRIDE;
         always_ff @(posedge i_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               en_r[g]          <= ckg_pkg::OUT_RST[ckg_pkg::F_EN];
               byp_r[g]         <= ckg_pkg::OUT_RST[ckg_pkg::F_BYP];
               inv_r[g]         <= ckg_pkg::OUT_RST[ckg_pkg::F_INV];
               hiz_r[g]         <= ckg_pkg::OUT_RST[ckg_pkg::F_HIZ];
               drv_r[2*g +: 2]  <= ckg_pkg::OUT_RST[ckg_pkg::F_DRV +: 2];
            end
            else if (wr_out)
            begin
               en_r[g]          <= i_wdata[B + ckg_pkg::F_EN];
               byp_r[g]         <= i_wdata[B + ckg_pkg::F_BYP];
               inv_r[g]         <= i_wdata[B + ckg_pkg::F_INV];
               hiz_r[g]         <= i_wdata[B + ckg_pkg::F_HIZ];
               drv_r[2*g +: 2]  <= i_wdata[B + ckg_pkg::F_DRV +: 2];
            end
         end
      end
   endgenerate

   // deviation limit follows the spread type written with it
   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ss_en_r   <= ckg_pkg::SS_EN_RST;
         ss_down_r <= 1'b0;
         dev_r     <= ckg_pkg::DEV_MIN;
         rate_r    <= ckg_pkg::RATE_MIN;
      end
      else if (wr_ss)
      begin
         ss_en_r   <= i_wdata[ckg_pkg::F_SS_EN];
         ss_down_r <= ss_down_wr;
         dev_r     <= ss_down_wr ? dev_dn_sat : dev_ctr_sat;
         rate_r    <= rate_sat;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         freq0_r <= ckg_pkg::FREQ_RST;
         freq1_r <= ckg_pkg::FREQ_RST;
         freq2_r <= ckg_pkg::FREQ_RST;
      end
      else
      begin
         freq0_r <= wr_freq0 ? freq_sat : freq0_r;
         freq1_r <= wr_freq1 ? freq_sat : freq1_r;
         freq2_r <= wr_freq2 ? freq_sat : freq2_r;
      end
   end

   // pair takes its settings from the second output
   // the first leg is true, the second is the complement
   // pair gated by the pair pin only
   assign eff_en[0]   = diff_r ? en_r[1] : en_r[0];
   assign eff_byp[0]  = diff_r ? byp_r[1] : byp_r[0];
   assign eff_inv[0]  = diff_r ? inv_r[1] : inv_r[0];
   assign eff_hiz[0]  = diff_r ? hiz_r[1] : hiz_r[0];
   // single-ended first output uses its own pin
   assign eff_gate[0] = diff_r ? i_pair_gate_pin : i_first_gate_pin;
   assign eff_hold[0] = 1'b0;
   assign eff_en[1]   = en_r[1];
   assign eff_byp[1]  = byp_r[1];
   assign eff_inv[1]  = diff_r ? ~inv_r[1] : inv_r[1];
   assign eff_hiz[1]  = hiz_r[1];
   assign eff_gate[1] = i_pair_gate_pin;
   assign eff_hold[1] = diff_r;
   assign eff_en[2]   = en_r[2];
   assign eff_byp[2]  = byp_r[2];
   assign eff_inv[2]  = inv_r[2];
   assign eff_hiz[2]  = hiz_r[2];
   assign eff_gate[2] = i_third_gate_pin;
   assign eff_hold[2] = 1'b0;

   ckg_chan_if chx[ckg_pkg::NCH] ();

   generate
      for (g = 0; g < ckg_pkg::NCH; g++)
      begin : g_ch
         assign chx[g].en      = eff_en[g];
         assign chx[g].byp     = eff_byp[g];
         assign chx[g].inv     = eff_inv[g];
         assign chx[g].hiz     = eff_hiz[g];
         assign chx[g].hold_hi = eff_hold[g];
         assign chx[g].gate    = eff_gate[g];
         assign ch_lvl[g]      = chx[g].lvl;
         assign ch_oe[g]       = chx[g].oe;
         // spread never reaches a bypassed output
         assign o_ss_applied[g] = ss_en_r & ~eff_byp[g];
         ckg_chan u_ch (
            .i_clk     (i_clk),
            .i_rst_n   (rst_n),
            .i_pd_n    (i_power_down_n_pin),
            .i_locked  (i_pll_locked),
            .i_ref_lvl (i_ref_clk_lvl),
            .i_syn_lvl (i_synth_clk_lvl),
            .bus       (chx[g].chan)
         );
      end
   endgenerate

   assign stat_word = {17'h0, o_ss_applied, 1'b0, ch_oe, 1'b0,
                       i_third_gate_pin, i_pair_gate_pin, i_first_gate_pin,
                       diff_r, src_r, i_power_down_n_pin, i_pll_locked};

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      rdata_nxt = 32'h00000000;
      if (!i_rd)
         rdata_nxt = 32'h00000000;
      else if (i_addr == ckg_pkg::OFF_CTRL)
         rdata_nxt = {26'h0, fmt_r, diff_r, load_r, src_r};
      else if (i_addr == ckg_pkg::OFF_LOAD)
         rdata_nxt = {23'h0, cap_r};
      else if (i_addr == ckg_pkg::OFF_OUT)
         rdata_nxt = {8'h00,
                      2'h0, drv_r[5:4], hiz_r[2], inv_r[2], byp_r[2], en_r[2],
                      2'h0, drv_r[3:2], hiz_r[1], inv_r[1], byp_r[1], en_r[1],
                      2'h0, drv_r[1:0], hiz_r[0], inv_r[0], byp_r[0], en_r[0]};
      else if (i_addr == ckg_pkg::OFF_SS)
         rdata_nxt = {8'h00, rate_r, 3'h0, dev_r, 6'h00, ss_down_r, ss_en_r};
      else if (i_addr == ckg_pkg::OFF_FREQ0)
         rdata_nxt = {4'h0, freq0_r};
      else if (i_addr == ckg_pkg::OFF_FREQ1)
         rdata_nxt = {4'h0, freq1_r};
      else if (i_addr == ckg_pkg::OFF_FREQ2)
         rdata_nxt = {4'h0, freq2_r};
      else if (i_addr == ckg_pkg::OFF_STAT)
         rdata_nxt = stat_word;
   end

   always_ff @(posedge i_clk or negedge rst_n)
   begin
      if (!rst_n)
         rdata_r <= 32'h00000000;
      else
         rdata_r <= rdata_nxt;
   end

   assign o_rdata               = rdata_r;
   assign o_first_clock_output  = ch_lvl[0];
   assign o_first_clock_oe      = ch_oe[0];
   assign o_second_clock_output = ch_lvl[1];
   assign o_second_clock_oe     = ch_oe[1];
   assign o_third_clock_output  = ch_lvl[2];
   assign o_third_clock_oe      = ch_oe[2];
   assign o_src_ref             = src_r;
   // internal caps out of circuit on reference input
   assign o_cap_int_en = ~src_r & (load_r != ckg_pkg::CKG_LOAD_EXT);
   assign o_cap_ext_en = ~src_r & (load_r != ckg_pkg::CKG_LOAD_INT);
   assign o_cap_code   = cap_r;
   assign o_diff_mode  = diff_r;
   assign o_diff_fmt   = fmt_r;
   assign o_drive      = drv_r;
   assign o_ss_en      = ss_en_r;
   assign o_ss_down    = ss_down_r;
   assign o_ss_dev     = dev_r;
   assign o_ss_rate    = rate_r;
   assign o_freq0      = freq0_r;
   assign o_freq1      = freq1_r;
   assign o_freq2      = freq2_r;

   AST_CAP_RANGE: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_load |=> o_cap_code <= ckg_pkg::CAP_MAX)
      else $error("load code beyond range");
   AST_CAP_BYPASS: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_ctrl && i_wdata[ckg_pkg::F_SRC] |=> !o_cap_int_en && !o_cap_ext_en)
      else $error("load caps active on reference input");
   AST_LOAD_EXT: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_ctrl && !i_wdata[ckg_pkg::F_SRC] && load_wr == 2'h1
      |=> !o_cap_int_en && o_cap_ext_en)
      else $error("external-only loading not applied");
   AST_DEV_DOWN: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_ss && ss_down_wr |=> o_ss_dev >= ckg_pkg::DEV_MIN && o_ss_dev <= ckg_pkg::DEV_DN_MAX)
      else $error("down spread deviation out of range");
   AST_RATE_RANGE: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_ss |=> o_ss_rate >= ckg_pkg::RATE_MIN && o_ss_rate <= ckg_pkg::RATE_MAX)
      else $error("modulation rate out of range");
   AST_FREQ_WRITE: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_freq1 && i_wdata[27:0] >= ckg_pkg::FREQ_MIN && i_wdata[27:0] <= ckg_pkg::FREQ_MAX
      |=> o_freq1 == $past(i_wdata[27:0])
          ##1 ($past(wr_freq1) || o_freq1 == $past(i_wdata[27:0], 2)))
      else $error("frequency write not applied");
   AST_FREQ_RANGE: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_freq2 |=> o_freq2 >= ckg_pkg::FREQ_MIN && o_freq2 <= ckg_pkg::FREQ_MAX)
      else $error("frequency out of range");
   AST_SS_BYPASS: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_out && i_wdata[ckg_pkg::OC_STRIDE * 2 + ckg_pkg::F_BYP] |=> !o_ss_applied[2])
      else $error("spread applied to bypassed output");
   AST_PAIR_GATE: assert property (@(posedge i_clk) disable iff (!rst_n)
      diff_r && !i_pair_gate_pin && i_first_gate_pin
      |=> !o_first_clock_output && !o_second_clock_output)
      else $error("pair not gated by the pair pin");
   AST_FIRST_GATE: assert property (@(posedge i_clk) disable iff (!rst_n)
      !diff_r && !i_first_gate_pin && i_pair_gate_pin |=> !o_first_clock_output)
      else $error("first output not gated by its own pin");
   AST_CFG_GATE: assert property (@(posedge i_clk) disable iff (!rst_n)
      !en_r[2] && i_third_gate_pin |=> !o_third_clock_output)
      else $error("output drives while disabled in configuration");
   AST_HOLD_DIFF: assert property (@(posedge i_clk) disable iff (!rst_n)
      diff_r && en_r[1] && i_pair_gate_pin && i_power_down_n_pin && !i_pll_locked
      |=> !o_first_clock_output && o_second_clock_output)
      else $error("pair not held low/high before lock");
   AST_DIFF_FMT: assert property (@(posedge i_clk) disable iff (!rst_n)
      wr_ctrl |=> o_diff_fmt == $past(i_wdata[ckg_pkg::F_FMT +: 2]))
      else $error("differential format not applied");
   AST_PD_ALL: assert property (@(posedge i_clk) disable iff (!rst_n)
      !i_power_down_n_pin |=> ch_lvl == 3'h0 && ch_oe == 3'h7)
      else $error("outputs not low in power-down");
endmodule

// file: tb/ckg_master.sv
/*
 Register master model on the far side of the configuration port.
 Assumes one clock; changes its signals just after rising edges.
*/
module ckg_master (
   input  logic        i_clk,
   input  logic [31:0] i_rdata,
   output logic [7:0]  o_addr,
   output logic [31:0] o_wdata,
   output logic        o_wr,
   output logic        o_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      o_addr = 8'h00;
      o_wdata = 32'h0;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_wdata <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1 d = i_rdata;
   endtask
   task automatic settle;
      repeat (2) @(posedge i_clk);
   endtask
endmodule

// file: tb/clock_output_config_control_test.sv
/*
 Register and pin scenarios for the clock output block.
 Assumes the master model in ckg_master.sv.
*/
module clock_output_config_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic        wr, rd, cint, cext, sref, dmode, sse, ssd;
   logic        rf = 1'b0, sy = 1'b0, lk = 1'b1, pd = 1'b1;
   logic [1:0]  dfmt;
   logic [4:0]  ssdev;
   logic [5:0]  drv;
   logic [7:0]  ssrate;
   logic [8:0]  cap;
   logic [27:0] f0, f1, f2;
   logic [2:0]  g = 3'h7, q, oe, ssa;
   int          err_total = 0, n_tests = 0;
   always #4 clk = ~clk;
   ckg_master u_ckg_master (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd));
   ckg_top u_ckg_top (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_ref_clk_lvl(rf), .i_synth_clk_lvl(sy), .i_pll_locked(lk),
      .i_power_down_n_pin(pd), .i_first_gate_pin(g[0]), .i_pair_gate_pin(g[1]),
      .i_third_gate_pin(g[2]), .o_first_clock_output(q[0]), .o_first_clock_oe(oe[0]),
      .o_second_clock_output(q[1]), .o_second_clock_oe(oe[1]), .o_third_clock_output(q[2]),
      .o_third_clock_oe(oe[2]), .o_src_ref(sref), .o_cap_int_en(cint), .o_cap_ext_en(cext),
      .o_cap_code(cap), .o_diff_mode(dmode), .o_diff_fmt(dfmt), .o_drive(drv), .o_ss_en(sse),
      .o_ss_down(ssd), .o_ss_dev(ssdev), .o_ss_rate(ssrate), .o_ss_applied(ssa), .o_freq0(f0),
      .o_freq1(f1), .o_freq2(f2));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      u_ckg_master.rd_reg(a, v);
      chk(v, exp);
   endtask
   // Pins {pd,lock,syn,ref} and gates, then compare {oe,q}
   task automatic pins(input logic [3:0] s, input logic [2:0] gg, input logic [5:0] exp);
      @(posedge clk);
      {pd, lk, sy, rf} <= s;
      g <= gg;
      u_ckg_master.settle();
      #1 chk({26'h0, oe, q}, {26'h0, exp});
   endtask
   task automatic close_out;
      $display("errors=%0d compares=%0d", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk(8'h00, 32'h0);
      rdchk(8'h04, 32'h0000_00B4);
      rdchk(8'h10, 32'h017D_7840);
      rdchk(8'h20, 32'h0);
      u_ckg_master.wr_reg(8'h10, 32'h0FFF_FFFF);
      rdchk(8'h10, 32'h0BEB_C200);
      chk({4'h0, f0}, 32'h0BEB_C200);
      u_ckg_master.wr_reg(8'h14, 32'h0001_0000);
      rdchk(8'h14, 32'h0001_0000);
      chk({4'h0, f1}, 32'h0001_0000);
      u_ckg_master.wr_reg(8'h18, 32'h0000_0001);
      rdchk(8'h18, 32'h0000_1F40);
      chk({4'h0, f2}, 32'h0000_1F40);
      u_ckg_master.wr_reg(8'h04, 32'h0000_01FF);
      rdchk(8'h04, 32'h0000_0140);
      chk({23'h0, cap}, 32'h0000_0140);
      u_ckg_master.wr_reg(8'h0C, 32'h0005_1F01);
      rdchk(8'h0C, 32'h001E_1801);
      chk({17'h0, sse, ssd, ssdev, ssrate}, 32'h0000_581E);
      // Rate kept at input 130; down deviation clipped to 16
      u_ckg_master.wr_reg(8'h0C, 32'h0082_1F03);
      rdchk(8'h0C, 32'h0082_1003);
      chk({17'h0, sse, ssd, ssdev, ssrate}, 32'h0000_7082);
      u_ckg_master.wr_reg(8'h08, 32'h0003_0107);
      pins(4'b1101, 3'b111, 6'h3C);
      chk({29'h0, ssa}, 32'h2);
      pins(4'b1110, 3'b111, 6'h3B);
      pins(4'b1101, 3'b011, 6'h38);
      u_ckg_master.wr_reg(8'h08, 32'h003B_0107);
      rdchk(8'h08, 32'h003B_0107);
      chk({26'h0, drv}, 32'h0000_0030);
      pins(4'b1101, 3'b011, 6'h18);
      pins(4'b1110, 3'b110, 6'h3A);
      for (int f = 0; f < 4; f++)
      begin
         u_ckg_master.wr_reg(8'h00, {26'h0, f[1:0], 1'b1, f[1:0], 1'b0});
         rdchk(8'h00, {26'h0, f[1:0], 1'b1, (f == 3) ? 2'd2 : f[1:0], 1'b0});
         chk({30'h0, cint, cext}, {30'h0, (f == 0) ? 2'b10 : (f == 1) ? 2'b01 : 2'b11});
      end
      pins(4'b1110, 3'b110, 6'h39);
      chk({28'h0, sref, dmode, dfmt}, 32'h0000_0007);
      pins(4'b1010, 3'b110, 6'h3A);
      pins(4'b1110, 3'b101, 6'h38);
      chk({31'h0, cint}, 32'h1);
      u_ckg_master.wr_reg(8'h00, 32'h1);
      pins(4'b1110, 3'b111, 6'h3B);
      chk({28'h0, sref, dmode, dfmt}, 32'h0000_0008);
      chk({30'h0, cint, cext}, 32'h0);
      pins(4'b1010, 3'b111, 6'h38);
      pins(4'b0110, 3'b111, 6'h38);
      pins(4'b1110, 3'b111, 6'h3B);
      close_out;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      err_total++;
      close_out;
   end
endmodule
